// *** hw/sdsp_ctrl.sv ***
// shuffler threshold registers, profile store and calibration sequencer
`timescale 1ns/10ps
module sdsp_ctrl
    import sdsp_pkg::*;
(
    input wire logic i_sys_clk, // converter clock
    input wire logic i_nrst, // asynchronous reset, low active
    input wire logic i_reg_wr, // register write strobe
    input wire logic i_reg_rd, // register read strobe
    input wire logic [9:0] i_reg_addr, // register offset
    input wire logic [7:0] i_reg_wdata, // write data
    input wire logic i_init_start, // start initialization calibration
    input wire logic signed [4:0] i_qcode, // quantizer output code
    output logic [7:0] o_reg_rdata, // read data, valid after read
    output logic o_reg_rvalid, // read data valid pulse
    output logic [15:0] o_elements, // unit element enables to dacs
    output logic o_shuffle_active, // shuffler active
    output logic [1:0] o_profile, // active profile index
    output logic [7:0] o_bandwidth, // active bandwidth
    output logic [7:0] o_center_frequency, // active center frequency
    output logic [7:0] o_margin_lower, // active lower edge extension
    output logic [7:0] o_margin_upper, // active upper edge extension
    output logic [7:0] o_margin_center, // active center offset
    output logic [6:0] o_dac_full_scale_current, // active dac code
    output logic [11:0] o_dac_current_ua, // dac full-scale current, microamps
    output logic o_cal_busy, // calibration running
    output logic [1:0] o_cal_profile // profile being calibrated
);
    logic rst_ff1;
    logic rst_n;
    logic [7:0] thresh_rate12;
    logic [7:0] thresh_rate34;
    logic [3:0] profile_define;
    logic [1:0] profile_select;
    logic [3:0] cal_done;
    sdsp_cal_e cal_state;
    sdsp_cal_e next_cal_state;
    logic [1:0] cal_idx;
    logic [11:0] cal_cnt;
    logic [7:0] bw_mem [NUM_PROFILES];
    logic [7:0] cf_mem [NUM_PROFILES];
    logic [7:0] ml_mem [NUM_PROFILES];
    logic [7:0] mu_mem [NUM_PROFILES];
    logic [7:0] mc_mem [NUM_PROFILES];
    logic [6:0] dac_mem [NUM_PROFILES];
    logic wr_bw;
    logic wr_cf;
    logic wr_ml;
    logic wr_mu;
    logic wr_mc;
    logic wr_dac;
    logic [3:0] nib_r1;
    logic [3:0] nib_r2;
    logic [3:0] nib_r3;
    logic [3:0] nib_r4;
    logic [3:0] next_thr;
    logic [1:0] next_rate;
    logic [7:0] next_rdata;
    logic [18:0] dac_product;
    logic cal_last;
    sdsp_shuf_if shuf_bus();

    // reset release through two flops
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_ff1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_ff1 <= 1'b1;
            rst_n <= rst_ff1;
        end
    end

    // write decode
    assign wr_bw = i_reg_wr && (i_reg_addr == ADDR_BANDWIDTH);
    assign wr_cf = i_reg_wr && (i_reg_addr == ADDR_CENTER_FREQ);
    assign wr_ml = i_reg_wr && (i_reg_addr == ADDR_MARGIN_LOWER);
    assign wr_mu = i_reg_wr && (i_reg_addr == ADDR_MARGIN_UPPER);
    assign wr_mc = i_reg_wr && (i_reg_addr == ADDR_MARGIN_CENTER);
    assign wr_dac = i_reg_wr && (i_reg_addr == ADDR_DAC_FS);

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            thresh_rate12 <= THRESH_R12_RST;
            thresh_rate34 <= THRESH_R34_RST;
            profile_define <= PROFILE_DEFINE_RST;
            profile_select <= PROFILE_SELECT_RST;
        end else if (i_reg_wr) begin
            if (i_reg_addr == ADDR_THRESH_R12) begin
                thresh_rate12 <= i_reg_wdata;
            end
            if (i_reg_addr == ADDR_THRESH_R34) begin
                thresh_rate34 <= i_reg_wdata;
            end
            if (i_reg_addr == ADDR_PROFILE_DEFINE) begin
                profile_define <= i_reg_wdata[3:0];
            end
            if (i_reg_addr == ADDR_PROFILE_SELECT) begin
                profile_select <= i_reg_wdata[1:0];
            end
        end
    end

    // parameter writes land in the profile currently selected
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PROFILES; gp++) begin : g_prof
            always_ff @(posedge i_sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    bw_mem[gp] <= BANDWIDTH_RST;
                    cf_mem[gp] <= CENTER_FREQ_RST;
                    ml_mem[gp] <= MARGIN_LOWER_RST;
                    mu_mem[gp] <= MARGIN_UPPER_RST;
                    mc_mem[gp] <= MARGIN_CENTER_RST;
                    dac_mem[gp] <= DAC_FS_RST;
                end else if (profile_select == 2'(gp)) begin
                    if (wr_bw) begin
                        bw_mem[gp] <= i_reg_wdata;
                    end
                    if (wr_cf) begin
                        cf_mem[gp] <= i_reg_wdata;
                    end
                    if (wr_ml) begin
                        ml_mem[gp] <= i_reg_wdata;
                    end
                    if (wr_mu) begin
                        mu_mem[gp] <= i_reg_wdata;
                    end
                    if (wr_mc) begin
                        mc_mem[gp] <= i_reg_wdata;
                    end
                    if (wr_dac) begin
                        dac_mem[gp] <= i_reg_wdata[6:0];
                    end
                end
            end
        end
    endgenerate

    // first nibble not off picks the rate, else shuffler is off
    assign nib_r1 = thresh_rate12[NIB_LO +: 4];
    assign nib_r2 = thresh_rate12[NIB_HI +: 4];
    assign nib_r3 = thresh_rate34[NIB_LO +: 4];
    assign nib_r4 = thresh_rate34[NIB_HI +: 4];

    always_comb begin
        next_thr = NIBBLE_OFF;
        next_rate = 2'h0;
        if (nib_r1 != NIBBLE_OFF) begin
            next_thr = nib_r1;
            next_rate = 2'h0;
        end else if (nib_r2 != NIBBLE_OFF) begin
            next_thr = nib_r2;
            next_rate = 2'h1;
        end else if (nib_r3 != NIBBLE_OFF) begin
            next_thr = nib_r3;
            next_rate = 2'h2;
        end else if (nib_r4 != NIBBLE_OFF) begin
            next_thr = nib_r4;
            next_rate = 2'h3;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shuf_bus.thr <= NIBBLE_OFF;
            shuf_bus.rate <= 2'h0;
            shuf_bus.qcode <= 5'sh00;
        end else begin
            shuf_bus.thr <= next_thr;
            shuf_bus.rate <= next_rate;
            shuf_bus.qcode <= i_qcode;
        end
    end

    sdsp_shuffler u_shuffler (
        .i_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .sh(shuf_bus)
    );

    assign o_elements = shuf_bus.elements;
    assign o_shuffle_active = shuf_bus.active;

    // calibration walks profiles 0 to 3, running marked ones
    assign cal_last = (cal_idx == 2'(NUM_PROFILES - 1));

    always_comb begin
        next_cal_state = cal_state;
        case (cal_state)
            CAL_IDLE: begin
                if (i_init_start) begin
                    next_cal_state = CAL_CHECK;
                end
            end
            CAL_CHECK: begin
                if (profile_define[cal_idx]) begin
                    next_cal_state = CAL_RUN;
                end else if (cal_last) begin
                    next_cal_state = CAL_IDLE;
                end
            end
            CAL_RUN: begin
                if (cal_cnt == CAL_CYCLES) begin
                    next_cal_state = cal_last ? CAL_IDLE : CAL_CHECK;
                end
            end
            default: begin
                next_cal_state = CAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_state <= CAL_IDLE;
        end else begin
            cal_state <= next_cal_state;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_idx <= 2'h0;
            cal_cnt <= 12'h000;
        end else if (cal_state == CAL_IDLE) begin
            cal_idx <= 2'h0;
            cal_cnt <= 12'h000;
        end else if (cal_state == CAL_CHECK) begin
            cal_cnt <= 12'h000;
            if (!profile_define[cal_idx]) begin
                cal_idx <= cal_idx + 2'h1;
            end
        end else if (cal_cnt == CAL_CYCLES) begin
            cal_cnt <= 12'h000;
            cal_idx <= cal_idx + 2'h1;
        end else begin
            cal_cnt <= cal_cnt + 12'h001;
        end
    end

    // done bits cleared by a new initialization
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_done <= 4'h0;
        end else if (cal_state == CAL_IDLE && i_init_start) begin
            cal_done <= 4'h0;
        end else if (cal_state == CAL_RUN && cal_cnt == CAL_CYCLES) begin
            cal_done[cal_idx] <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_cal_busy <= 1'b0;
            o_cal_profile <= 2'h0;
        end else begin
            o_cal_busy <= (next_cal_state != CAL_IDLE);
            o_cal_profile <= cal_idx;
        end
    end

    // active profile outputs: two cycles after the select write strobe;
    // no clock, decimation or link setting lives in the profile store
    assign dac_product = 19'(dac_mem[profile_select]) * 19'(DAC_FULL_UA);

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_profile <= PROFILE_SELECT_RST;
            o_bandwidth <= BANDWIDTH_RST;
            o_center_frequency <= CENTER_FREQ_RST;
            o_margin_lower <= MARGIN_LOWER_RST;
            o_margin_upper <= MARGIN_UPPER_RST;
            o_margin_center <= MARGIN_CENTER_RST;
            o_dac_full_scale_current <= DAC_FS_RST;
            o_dac_current_ua <= 12'h000;
        end else begin
            o_profile <= profile_select;
            o_bandwidth <= bw_mem[profile_select];
            o_center_frequency <= cf_mem[profile_select];
            o_margin_lower <= ml_mem[profile_select];
            o_margin_upper <= mu_mem[profile_select];
            o_margin_center <= mc_mem[profile_select];
            o_dac_full_scale_current <= dac_mem[profile_select];
            o_dac_current_ua <= dac_product[DAC_CODE_SHIFT +: 12];
        end
    end

    // register read mux, parameters shown for the selected profile
    always_comb begin
        next_rdata = 8'h00;
        case (i_reg_addr)
            ADDR_BANDWIDTH: next_rdata = bw_mem[profile_select];
            ADDR_CENTER_FREQ: next_rdata = cf_mem[profile_select];
            ADDR_MARGIN_LOWER: next_rdata = ml_mem[profile_select];
            ADDR_MARGIN_UPPER: next_rdata = mu_mem[profile_select];
            ADDR_MARGIN_CENTER: next_rdata = mc_mem[profile_select];
            ADDR_DAC_FS: next_rdata = {1'b0, dac_mem[profile_select]};
            ADDR_PROFILE_DEFINE: next_rdata = {4'h0, profile_define};
            ADDR_CAL_STATUS: next_rdata = {3'h0, o_cal_busy, cal_done};
            ADDR_PROFILE_SELECT: next_rdata = {6'h00, profile_select};
            ADDR_THRESH_R12: next_rdata = thresh_rate12;
            ADDR_THRESH_R34: next_rdata = thresh_rate34;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= next_rdata;
            end
        end
    end
endmodule

// *** hw/sdsp_pkg.sv ***
// constants, register map and types for the shuffler and profile control
package sdsp_pkg;
    // register offsets on the serial register port
    localparam logic [9:0] ADDR_BANDWIDTH = 10'h105;
    localparam logic [9:0] ADDR_CENTER_FREQ = 10'h106;
    localparam logic [9:0] ADDR_MARGIN_LOWER = 10'h107;
    localparam logic [9:0] ADDR_MARGIN_UPPER = 10'h108;
    localparam logic [9:0] ADDR_MARGIN_CENTER = 10'h109;
    localparam logic [9:0] ADDR_DAC_FS = 10'h10a;
    localparam logic [9:0] ADDR_PROFILE_DEFINE = 10'h115;
    localparam logic [9:0] ADDR_CAL_STATUS = 10'h116;
    localparam logic [9:0] ADDR_PROFILE_SELECT = 10'h118;
    localparam logic [9:0] ADDR_THRESH_R12 = 10'h342;
    localparam logic [9:0] ADDR_THRESH_R34 = 10'h343;
    // reset values
    localparam logic [7:0] THRESH_R12_RST = 8'hf5;
    localparam logic [7:0] THRESH_R34_RST = 8'hff;
    localparam logic [3:0] PROFILE_DEFINE_RST = 4'h1;
    localparam logic [1:0] PROFILE_SELECT_RST = 2'h0;
    localparam logic [7:0] BANDWIDTH_RST = 8'h50;
    localparam logic [7:0] CENTER_FREQ_RST = 8'h00;
    localparam logic [7:0] MARGIN_LOWER_RST = 8'h05;
    localparam logic [7:0] MARGIN_UPPER_RST = 8'h05;
    localparam logic [7:0] MARGIN_CENTER_RST = 8'h00;
    localparam logic [6:0] DAC_FS_RST = 7'h40;
    // field layout
    localparam int NIB_LO = 0;
    localparam int NIB_HI = 4;
    localparam int STATUS_BUSY_BIT = 4;
    localparam logic [3:0] NIBBLE_OFF = 4'hf;
    localparam logic [3:0] THR_ALWAYS = 4'h0;
    localparam int NUM_PROFILES = 4;
    localparam int NUM_ELEMENTS = 16;
    localparam int QCODE_W = 5;
    localparam logic [4:0] QCODE_OFFSET = 5'h08;
    // timing
    localparam logic [4:0] HOLD_CYCLES = 5'h10;
    localparam logic [11:0] CAL_CYCLES = 12'h100;
    localparam int CLK_MHZ = 40;
    localparam int PROFILE_SWITCH_NS = 1000;
    localparam int PROFILE_SWITCH_CYCLES = PROFILE_SWITCH_NS * CLK_MHZ / 1000;
    // element selection sequence
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    // dac full-scale current in microamps is full value times code over 64
    localparam logic [11:0] DAC_FULL_UA = 12'hfa0;
    localparam int DAC_CODE_SHIFT = 6;
    typedef enum logic [1:0] {CAL_IDLE, CAL_CHECK, CAL_RUN} sdsp_cal_e;
endpackage

// *** hw/sdsp_shuf_if.sv ***
// carrier between profile control and the element shuffler
`timescale 1ns/10ps
interface sdsp_shuf_if;
    logic [3:0] thr;
    logic [1:0] rate;
    logic signed [4:0] qcode;
    logic active;
    logic [15:0] elements;
    modport ctrl(output thr, output rate, output qcode, input active, input elements);
    modport shuf(input thr, input rate, input qcode, output active, output elements);
endinterface

// *** hw/sdsp_shuffler.sv ***
// adaptive element shuffler: gating, pacing and randomised element map
`timescale 1ns/10ps
module sdsp_shuffler
    import sdsp_pkg::*;
(
    input wire logic i_clk, // converter clock
    input wire logic i_rst_n, // synchronised reset, low active
    sdsp_shuf_if.shuf sh // control and element map
);
    logic [3:0] mag;
    logic trig;
    logic tick;
    logic [4:0] hold;
    logic [1:0] pace;
    logic [15:0] lfsr;
    logic [3:0] offset;
    logic active;
    logic [4:0] level;
    logic [15:0] therm;
    logic [31:0] doubled;
    logic [15:0] rotated;

    assign mag = sh.qcode[4] ? 4'(-sh.qcode) : sh.qcode[3:0];
    assign trig = (sh.thr != NIBBLE_OFF) &&
        ((sh.thr == THR_ALWAYS) || (mag >= sh.thr));
    assign tick = (pace >= sh.rate);
    assign level = sh.qcode + QCODE_OFFSET;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_ELEMENTS; gi++) begin : g_therm
            assign therm[gi] = (level > 5'(gi));
        end
    endgenerate

    assign doubled = {therm, therm};
    assign rotated = doubled[offset +: 16];

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hold <= 5'h00;
        end else if (sh.thr == NIBBLE_OFF) begin
            hold <= 5'h00;
        end else if (trig) begin
            hold <= HOLD_CYCLES;
        end else if (hold != 5'h00) begin
            hold <= hold - 5'h01;
        end
    end

    assign active = trig || (hold != 5'h00);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pace <= 2'h0;
        end else begin
            pace <= tick ? 2'h0 : pace + 2'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lfsr <= LFSR_SEED;
        end else if (tick) begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            offset <= 4'h0;
        end else if (!active) begin
            offset <= 4'h0;
        end else if (tick) begin
            offset <= lfsr[3:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sh.elements <= 16'h0000;
            sh.active <= 1'b0;
        end else begin
            sh.elements <= rotated;
            sh.active <= active;
        end
    end
endmodule

// *** test/sdsp_qdac_model.sv ***
// quantizer and unit element array model for the shuffler bench
`timescale 1ns/10ps
module sdsp_qdac_model
    import sdsp_pkg::*;
(
    input wire logic i_clk, // converter clock
    input wire logic i_chk, // compare enable
    input wire logic signed [4:0] i_level, // wanted code
    input wire logic [15:0] i_elements, // element enables
    output logic signed [4:0] o_qcode, // quantizer code
    output int o_errs // element count mismatches
);
    logic signed [4:0] q1;
    logic signed [4:0] q2;
    assign o_qcode = i_level > 5'sd8 ? 5'sd8 : i_level < -5'sd8 ? -5'sd8 : i_level;
    always @(posedge i_clk) begin
        if (!i_chk) begin
            o_errs <= 0;
        end else if ($countones(i_elements) != int'(q2) + 8) begin
            o_errs <= o_errs + 1;
        end
        q1 <= o_qcode;
        q2 <= q1;
    end
endmodule

// *** test/sdsp_ctrl_properties.sv ***
// port checks for shuffler gating, register answers and profile switching
`timescale 1ns/10ps
module sdsp_ctrl_chk
    import sdsp_pkg::*;
(
    input wire logic i_sys_clk, // clock
    input wire logic i_nrst, // reset, low active
    input wire logic i_reg_wr, // write strobe
    input wire logic i_reg_rd, // read strobe
    input wire logic [9:0] i_reg_addr, // offset
    input wire logic [7:0] i_reg_wdata, // write data
    input wire logic i_init_start, // calibration start
    input wire logic signed [4:0] i_qcode, // quantizer code
    input wire logic [7:0] o_reg_rdata, // read data
    input wire logic o_reg_rvalid, // read valid
    input wire logic [15:0] o_elements, // element enables
    input wire logic o_shuffle_active, // shuffler on
    input wire logic [1:0] o_profile, // active profile
    input wire logic [6:0] o_dac_full_scale_current, // dac code
    input wire logic [11:0] o_dac_current_ua, // dac current
    input wire logic o_cal_busy // calibration running
);
    logic [3:0] up_cnt;
    logic [7:0] r12;
    logic [7:0] r34;
    logic [4:0] quiet;
    wire live = up_cnt == 4'hf;
    wire [3:0] thr = r12[3:0] != 4'hf ? r12[3:0] : r12[7:4] != 4'hf ? r12[7:4] :
        r34[3:0] != 4'hf ? r34[3:0] : r34[7:4];
    wire [4:0] qneg = -i_qcode;
    wire [3:0] qmag = i_qcode[4] ? qneg[3:0] : i_qcode[3:0];
    wire trig = thr != 4'hf && qmag >= thr;
    wire wr12 = i_reg_wr && i_reg_addr == ADDR_THRESH_R12;
    wire wr34 = i_reg_wr && i_reg_addr == ADDR_THRESH_R34;
    wire thr_rd = live && i_reg_rd &&
        (i_reg_addr == ADDR_THRESH_R12 || i_reg_addr == ADDR_THRESH_R34);
    wire [7:0] thr_reg = i_reg_addr == ADDR_THRESH_R34 ? r34 : r12;
    wire sel_wr = live && i_reg_wr && i_reg_addr == ADDR_PROFILE_SELECT;
    wire [18:0] ua_full = 19'(o_dac_full_scale_current) * 19'd4000;
    // cycles since the last trigger, parked at 31 when unknown
    wire [4:0] next_quiet = wr12 || wr34 ? 5'h1f : trig ? 5'h0 :
        quiet == 5'h1f ? quiet : quiet + 5'h1;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            up_cnt <= 4'h0;
            r12 <= THRESH_R12_RST;
            r34 <= THRESH_R34_RST;
            quiet <= 5'h1f;
        end else begin
            up_cnt <= live ? up_cnt : up_cnt + 4'h1;
            r12 <= wr12 ? i_reg_wdata : r12;
            r34 <= wr34 ? i_reg_wdata : r34;
            quiet <= next_quiet;
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    rd_answer_a: assert property (live |-> o_reg_rvalid == $past(i_reg_rd))
        else $error("read valid not one cycle after strobe");
    thr_readback_a: assert property (thr_rd |=> o_reg_rdata == $past(thr_reg))
        else $error("threshold register readback wrong");
    elem_count_a: assert property (live |->
        $countones(o_elements) == int'($past(i_qcode, 2)) + 8)
        else $error("element count does not follow code");
    always_on_a: assert property ((live && thr == 4'h0) [*4] |-> o_shuffle_active)
        else $error("zero threshold left shuffler off");
    always_off_a: assert property ((live && r12 == 8'hff && r34 == 8'hff) [*4] |->
        !o_shuffle_active)
        else $error("disabled shuffler still active");
    hold_on_a: assert property (quiet inside {[5'd1:5'd17]} |->
        o_shuffle_active)
        else $error("shuffler dropped inside hold time");
    hold_off_a: assert property (quiet inside {[5'd19:5'd24]} |-> !o_shuffle_active)
        else $error("shuffler still active after hold time");
    prof_switch_a: assert property (sel_wr |->
        ##2 o_profile == 2'($past(i_reg_wdata, 2)))
        else $error("profile not switched in time");
    no_recal_a: assert property (sel_wr && !o_cal_busy && !i_init_start |=>
        !o_cal_busy [*4])
        else $error("profile switch started calibration");
    dac_scale_a: assert property (live && $stable(o_dac_full_scale_current) |->
        o_dac_current_ua == ua_full[17:6])
        else $error("dac current not code times 4000 over 64");
    cal_start_a: assert property (live && i_init_start && !o_cal_busy |=> o_cal_busy)
        else $error("calibration did not start");
    cover property (live && thr == 4'h0 && o_shuffle_active);
    cover property (quiet == 5'd20);
    cover property ($fell(o_cal_busy));
endmodule
bind sdsp_ctrl sdsp_ctrl_chk u_chk (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_init_start(i_init_start), .i_qcode(i_qcode), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .o_elements(o_elements), .o_shuffle_active(o_shuffle_active),
    .o_profile(o_profile), .o_dac_full_scale_current(o_dac_full_scale_current),
    .o_dac_current_ua(o_dac_current_ua), .o_cal_busy(o_cal_busy));

// *** test/sigma_delta_shuffler_profile_ctrl_tb_top.sv ***
// self-checking bench for shuffler thresholds, rates, hold and profiles
`timescale 1ns/10ps
module sigma_delta_shuffler_profile_ctrl_tb_top
    import sdsp_pkg::*;
;
    typedef struct {logic [7:0] r12; logic [7:0] r34; int rate; logic act;} sdsp_row_s;
    sdsp_row_s rows [5] = '{'{8'hf0, 8'hff, 1, 1'b1}, '{8'h0f, 8'hff, 2, 1'b1},
        '{8'hff, 8'hf0, 3, 1'b1}, '{8'hff, 8'h0f, 4, 1'b1}, '{8'hff, 8'hff, 1, 1'b0}};
    logic clk;
    logic nrst;
    logic wr;
    logic rd;
    logic [9:0] addr;
    logic [7:0] wdata;
    logic init;
    logic chk;
    logic signed [4:0] level;
    logic signed [4:0] qcode;
    logic [7:0] rdata;
    logic rvalid;
    logic [15:0] elems;
    logic act;
    logic [1:0] prof;
    logic [7:0] bw;
    logic [7:0] cf, ml, mu, mc;
    logic [1:0] calp;
    logic [11:0] ua;
    logic busy;
    logic [15:0] prev;
    int merr;
    int err_count;
    int checked;
    int n;
    sdsp_ctrl u_dut (.i_sys_clk(clk), .i_nrst(nrst), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_init_start(init), .i_qcode(qcode),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_elements(elems), .o_shuffle_active(act),
        .o_profile(prof), .o_bandwidth(bw), .o_center_frequency(cf), .o_margin_lower(ml),
        .o_margin_upper(mu), .o_margin_center(mc), .o_dac_full_scale_current(),
        .o_dac_current_ua(ua), .o_cal_busy(busy), .o_cal_profile(calp));
    sdsp_qdac_model u_model (.i_clk(clk), .i_chk(chk), .i_level(level), .i_elements(elems),
        .o_qcode(qcode), .o_errs(merr));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [9:0] a, input logic [7:0] exp, input string msg);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rvalid === 1'b1 && rdata === exp, msg);
    endtask
    task automatic print_verdict();
        err_count += merr;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        print_verdict();
    end
    initial begin
        {nrst, wr, rd, init, chk, addr, wdata, level} = '0;
        err_count = 0;
        checked = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        reg_rd(ADDR_THRESH_R12, THRESH_R12_RST, "rate12 reset value");
        reg_rd(ADDR_THRESH_R34, THRESH_R34_RST, "rate34 reset value");
        chk <= 1'b1;
        reg_rd(10'h3ff, 8'h00, "unmapped read");
        check(act === 1'b0 && ua === DAC_FULL_UA, "reset outputs");
        @(posedge clk) level <= 5'sd3;
        foreach (rows[i]) begin
            reg_wr(ADDR_THRESH_R12, rows[i].r12);
            reg_wr(ADDR_THRESH_R34, rows[i].r34);
            reg_rd(ADDR_THRESH_R12, rows[i].r12, "rate12 readback");
            reg_rd(ADDR_THRESH_R34, rows[i].r34, "rate34 readback");
            cyc(6);
            n = 0;
            prev = elems;
            repeat (24) begin
                @(negedge clk);
                n += int'(elems !== prev);
                prev = elems;
            end
            check(act === rows[i].act, "active level for rate");
            check(n <= 24 / rows[i].rate, "reshuffled too often");
            check((n > 0) === rows[i].act, "element map not shuffled");
        end
        reg_wr(ADDR_THRESH_R12, THRESH_R12_RST);
        reg_wr(ADDR_THRESH_R34, THRESH_R34_RST);
        @(posedge clk) level <= 5'sd4;
        cyc(30);
        check(act === 1'b0, "below threshold triggered");
        @(posedge clk) level <= -5'sd5;
        @(posedge clk) level <= 5'sd4;
        cyc(10);
        check(act === 1'b1, "dropped inside hold");
        cyc(15);
        check(act === 1'b0, "hold did not end");
        @(posedge clk) level <= 5'sd5;
        cyc(4);
        check(act === 1'b1, "positive peak ignored");
        reg_wr(ADDR_PROFILE_SELECT, 8'h02);
        reg_wr(ADDR_BANDWIDTH, 8'h33);
        reg_wr(ADDR_DAC_FS, 8'h20);
        reg_wr(ADDR_CENTER_FREQ, 8'h21);
        reg_wr(ADDR_MARGIN_UPPER, 8'h10);
        cyc(3);
        check(prof === 2'h2 && bw === 8'h33, "profile two not active");
        check(ua === 12'h7d0, "half code current");
        check(cf === 8'h21 && mu === 8'h10 && mc === MARGIN_CENTER_RST, "p2 params");
        reg_wr(ADDR_PROFILE_SELECT, 8'h00);
        cyc(PROFILE_SWITCH_CYCLES);
        check(prof === 2'h0 && bw === BANDWIDTH_RST, "switch back");
        check(ml === MARGIN_LOWER_RST && ua === DAC_FULL_UA, "p0 params");
        check(busy === 1'b0, "switch recalibrated");
        reg_wr(ADDR_PROFILE_DEFINE, 8'h05);
        @(posedge clk) init <= 1'b1;
        @(posedge clk) init <= 1'b0;
        cyc(1);
        check(busy === 1'b1 && calp === 2'h0, "calibration not started");
        n = 0;
        while (busy === 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        check((n - 2 * int'(CAL_CYCLES)) inside {[2:12]}, "cal time");
        reg_rd(ADDR_CAL_STATUS, 8'h05, "calibrated profiles");
        print_verdict();
    end
endmodule
